// ---- common/ctb_pkg.sv ----
// Constants, register map and state carrier for the transmit buffer control block
package ctb_pkg;

  localparam int unsigned NBUF = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_EMPTY_FLAGS = 8'h06;
  localparam logic [7:0] OFS_TX_EMPTY_IRQ_ENABLE = 8'h07;
  localparam logic [7:0] OFS_ABORT_REQUEST = 8'h08;
  localparam logic [7:0] OFS_ABORT_ACKNOWLEDGE = 8'h09;
  localparam logic [7:0] OFS_BUFFER_SELECT = 8'h0a;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVT_ENABLE = 8'h11;
  localparam logic [7:0] OFS_EVT_CLEAR = 8'h12;

  // Transmit window: byte addresses WIN_BASE .. WIN_BASE + 15, matched through WIN_MASK
  localparam logic [7:0] WIN_BASE = 8'h20;
  localparam logic [7:0] WIN_MASK = 8'hf0;

  // Reset values
  localparam logic [2:0] EMPTY_RST = 3'h7;
  localparam logic [2:0] TXEIE_RST = 3'h0;
  localparam logic [2:0] ABRQ_RST = 3'h0;
  localparam logic [2:0] ABAK_RST = 3'h0;
  localparam logic [2:0] BSEL_RST = 3'h0;
  localparam logic [2:0] EVT_RST = 3'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Event status bit positions
  localparam int unsigned EVT_SENT = 0;
  localparam int unsigned EVT_ABORTED = 1;
  localparam int unsigned EVT_BLOCKED = 2;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ctb_bus_req_t;

  // Protocol engine report, one bit per buffer
  typedef struct packed {
    logic [NBUF-1:0] sent;
    logic [NBUF-1:0] active;
  } ctb_eng_rpt_t;

  // Whole state of the block
  typedef struct packed {
    logic [NBUF-1:0] empty;
    logic [NBUF-1:0] txeie;
    logic [NBUF-1:0] abrq;
    logic [NBUF-1:0] abak;
    logic [NBUF-1:0] bsel;
    logic [2:0] evt_st;
    logic [2:0] evt_en;
    logic [7:0] rdata;
  } ctb_state_t;

endpackage : ctb_pkg

// ---- src/ctb_tx_buffer_control.sv ----
// Transmit buffer control: enables, abort request/acknowledge, buffer select, window gate
`timescale 1ns/100ps

module ctb_tx_buffer_control (
  input wire logic mclk_i, // 40 MHz module clock
  input wire logic rst_n_i, // Asynchronous reset, active low
  input wire logic [7:0] addr_i, // Register byte address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after the read strobe
  input wire logic init_request_i, // Init mode request
  input wire logic init_acknowledge_i, // Init mode acknowledge
  input wire logic [2:0] eng_sent_i, // Engine: buffer sent successfully, pulse
  input wire logic [2:0] eng_active_i, // Engine: buffer transmission under way
  output logic [2:0] scheduled_o, // Buffers scheduled for transmission
  output logic [2:0] abort_req_o, // Pending abort requests
  output logic [2:0] window_sel_o, // One-hot buffer mapped into the window
  output logic window_open_o, // Window accessible now
  output logic win_wr_o, // Window write strobe, granted
  output logic win_rd_o, // Window read strobe, granted
  output logic [3:0] win_addr_o, // Byte index inside the window
  output logic [7:0] win_wdata_o, // Window write data
  input wire logic [7:0] win_rdata_i, // Window read data, same cycle as win_rd_o
  output logic tx_empty_irq_o, // Transmitter empty interrupt request
  output logic irq_o // Event interrupt, level
);

  ctb_pkg::ctb_state_t state_reg;
  ctb_pkg::ctb_state_t state_next;
  ctb_pkg::ctb_bus_req_t req;
  ctb_pkg::ctb_eng_rpt_t rpt;

  logic init_mode;
  logic wr_ok;
  logic win_hit;
  logic [2:0] grant;
  logic [2:0] sent;
  logic [2:0] empty_set;
  logic [2:0] empty_clr;
  logic [2:0] evt_set;
  logic [2:0] evt_clr;
  logic [2:0] wr_low;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign rpt = '{sent: eng_sent_i, active: eng_active_i};

  // ****************************************************************
  // Mode and decode
  // ****************************************************************
  assign init_mode = init_request_i & init_acknowledge_i;
  // Half-way between modes: transmit registers neither held nor writable
  assign wr_ok = ~init_request_i & ~init_acknowledge_i;
  assign win_hit = (req.addr & ctb_pkg::WIN_MASK) == ctb_pkg::WIN_BASE;

  // Lowest one bit of the written select value
  assign wr_low = req.wdata[2:0] & (~req.wdata[2:0] + 3'h1);

  // ****************************************************************
  // Buffer events
  // ****************************************************************
  // Sent has priority: a buffer that completes is not counted as aborted
  assign sent = rpt.sent & ~state_reg.empty;
  // Abort granted while the buffer is idle on the bus, incl. after lost arbitration
  assign grant = state_reg.abrq & ~state_reg.empty & ~rpt.active & ~sent
    & {3{~init_mode}};
  assign empty_set = sent | grant;
  assign empty_clr = (wr_ok && req.wr && req.addr == ctb_pkg::OFS_EMPTY_FLAGS)
    ? req.wdata[2:0] : 3'h0;

  assign evt_set[ctb_pkg::EVT_SENT] = |sent;
  assign evt_set[ctb_pkg::EVT_ABORTED] = |grant;
  assign evt_set[ctb_pkg::EVT_BLOCKED] = win_hit & (req.wr | req.rd) & ~window_open_o;
  assign evt_clr = (req.wr && req.addr == ctb_pkg::OFS_EVT_CLEAR) ? req.wdata[2:0] : 3'h0;

  // ****************************************************************
  // Transmit window gate
  // ****************************************************************
  assign window_sel_o = state_reg.bsel;
  // Scheduled buffers are owned by the engine, so the CPU keeps its hands off
  assign window_open_o = |(state_reg.bsel & state_reg.empty);
  assign win_wr_o = req.wr & win_hit & window_open_o;
  assign win_rd_o = req.rd & win_hit & window_open_o;
  assign win_addr_o = req.addr[3:0];
  assign win_wdata_o = req.wdata;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;

    // Empty flags: hardware set wins over software clear
    state_next.empty = (state_reg.empty & ~empty_clr) | empty_set;

    if (wr_ok && req.wr) begin
      unique case (req.addr)
        ctb_pkg::OFS_TX_EMPTY_IRQ_ENABLE: begin
          state_next.txeie = req.wdata[2:0];
        end
        ctb_pkg::OFS_ABORT_REQUEST: begin
          // Ones only add, and only for buffers still scheduled
          state_next.abrq = state_reg.abrq | (req.wdata[2:0] & ~state_reg.empty);
        end
        ctb_pkg::OFS_BUFFER_SELECT: begin
          state_next.bsel = wr_low;
        end
        default: begin
        end
      endcase
    end

    if (req.wr && req.addr == ctb_pkg::OFS_EVT_ENABLE) begin
      state_next.evt_en = req.wdata[2:0];
    end

    // Abort requests die with the empty flag
    state_next.abrq = state_next.abrq & ~state_next.empty;
    // Acknowledge set on grant, dropped when the buffer is scheduled again
    state_next.abak = (state_reg.abak | grant) & state_next.empty;

    // Sticky events, set wins over clear
    state_next.evt_st = (state_reg.evt_st & ~evt_clr) | evt_set;

    // Read data stands one cycle only
    state_next.rdata = ctb_pkg::RDATA_RST;
    if (req.rd) begin
      if (win_hit) begin
        state_next.rdata = window_open_o ? win_rdata_i : ctb_pkg::RDATA_RST;
      end else begin
        unique case (req.addr)
          ctb_pkg::OFS_EMPTY_FLAGS: state_next.rdata = {5'h00, state_reg.empty};
          ctb_pkg::OFS_TX_EMPTY_IRQ_ENABLE: state_next.rdata = {5'h00, state_reg.txeie};
          ctb_pkg::OFS_ABORT_REQUEST: state_next.rdata = {5'h00, state_reg.abrq};
          ctb_pkg::OFS_ABORT_ACKNOWLEDGE: state_next.rdata = {5'h00, state_reg.abak};
          ctb_pkg::OFS_BUFFER_SELECT: state_next.rdata = {5'h00, state_reg.bsel};
          ctb_pkg::OFS_EVT_STATUS: state_next.rdata = {5'h00, state_reg.evt_st};
          ctb_pkg::OFS_EVT_ENABLE: state_next.rdata = {5'h00, state_reg.evt_en};
          default: state_next.rdata = ctb_pkg::RDATA_RST;
        endcase
      end
    end

    // Init mode pins the transmit registers at their reset values
    if (init_mode) begin
      state_next.empty = ctb_pkg::EMPTY_RST;
      state_next.txeie = ctb_pkg::TXEIE_RST;
      state_next.abrq = ctb_pkg::ABRQ_RST;
      state_next.abak = ctb_pkg::ABAK_RST;
      state_next.bsel = ctb_pkg::BSEL_RST;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '{empty: ctb_pkg::EMPTY_RST, txeie: ctb_pkg::TXEIE_RST,
                     abrq: ctb_pkg::ABRQ_RST, abak: ctb_pkg::ABAK_RST,
                     bsel: ctb_pkg::BSEL_RST, evt_st: ctb_pkg::EVT_RST,
                     evt_en: ctb_pkg::EVT_RST, rdata: ctb_pkg::RDATA_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_o = state_reg.rdata;
  assign scheduled_o = ~state_reg.empty;
  assign abort_req_o = state_reg.abrq;
  // Level request while an enabled buffer is empty
  assign tx_empty_irq_o = |(state_reg.empty & state_reg.txeie);
  assign irq_o = |(state_reg.evt_st & state_reg.evt_en);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_init_hold_regs: assert property (
    (init_request_i && init_acknowledge_i) |=>
      (state_reg.txeie == 3'h0 && state_reg.abrq == 3'h0 &&
       state_reg.abak == 3'h0 && state_reg.bsel == 3'h0))
    else $error("transmit registers not held in init mode");

  a_enable_no_write: assert property (
    (wr_i && addr_i == ctb_pkg::OFS_TX_EMPTY_IRQ_ENABLE &&
     (init_request_i || init_acknowledge_i) && !(init_request_i && init_acknowledge_i))
      |=> $stable(state_reg.txeie))
    else $error("enable register written outside normal mode");

  a_empty_irq_gate: assert property (
    $rose(state_reg.empty[0]) && state_reg.txeie[0] |-> tx_empty_irq_o)
    else $error("empty event on enabled buffer raised no request");

  a_grant_sets_flags: assert property (
    (grant != 3'h0) |=> ((state_reg.empty & $past(grant)) == $past(grant) &&
                         (state_reg.abak & $past(grant)) == $past(grant)))
    else $error("granted abort did not set empty and acknowledge");

  a_abort_req_clear: assert property (
    (state_reg.abrq & state_reg.empty) == 3'h0)
    else $error("abort request pending on empty buffer");

  a_abort_zero_keep: assert property (
    (wr_i && addr_i == ctb_pkg::OFS_ABORT_REQUEST && wdata_i[2:0] == 3'h0 &&
     !init_mode && empty_set == 3'h0)
      |=> state_reg.abrq == $past(state_reg.abrq))
    else $error("writing zero changed abort requests");

  a_ack_follows_empty: assert property (
    (state_reg.abak & ~state_reg.empty) == 3'h0)
    else $error("acknowledge set on scheduled buffer");

  a_select_lowest_bit: assert property (
    (wr_i && wr_ok && addr_i == ctb_pkg::OFS_BUFFER_SELECT && wdata_i[2:0] == 3'h6)
      ##1 !init_mode |-> state_reg.bsel == 3'h2)
    else $error("buffer select kept more than the lowest bit");

  a_window_blocked: assert property (
    (win_wr_o || win_rd_o) |-> (state_reg.bsel != 3'h0 &&
                               (state_reg.bsel & ~state_reg.empty) == 3'h0))
    else $error("window access to unselected or scheduled buffer");

  a_upper_zero: assert property (
    rd_i && addr_i == ctb_pkg::OFS_ABORT_REQUEST |=> rdata_o[7:3] == 5'h00)
    else $error("abort request upper bits not zero");

  // Normal-mode writes land, refused ones leave no trace
  a_enable_write_lands: assert property (
    (wr_i && wr_ok && addr_i == ctb_pkg::OFS_TX_EMPTY_IRQ_ENABLE)
      |=> state_reg.txeie == $past(wdata_i[2:0]))
    else $error("enable write did not land");

  a_irq_needs_enable: assert property (
    tx_empty_irq_o |-> (state_reg.txeie & state_reg.empty) != 3'h0)
    else $error("empty request without enabled empty buffer");

  a_irq_on_enabled: assert property (
    (state_reg.txeie & state_reg.empty) != 3'h0 |-> tx_empty_irq_o)
    else $error("enabled empty buffer raised no request");

  a_abort_write_sets: assert property (
    (wr_i && wr_ok && addr_i == ctb_pkg::OFS_ABORT_REQUEST)
      |=> ($past(wdata_i[2:0] & ~state_reg.empty)
           & ~(state_reg.abrq | state_reg.empty)) == 3'h0)
    else $error("abort request for scheduled buffer lost");

  a_abort_no_write: assert property (
    (wr_i && !wr_ok && addr_i == ctb_pkg::OFS_ABORT_REQUEST)
      |=> (state_reg.abrq & ~$past(state_reg.abrq)) == 3'h0)
    else $error("abort request written outside normal mode");

  a_abort_empty_none: assert property (
    (wr_i && addr_i == ctb_pkg::OFS_ABORT_REQUEST)
      |=> (state_reg.abrq & $past(state_reg.empty)) == 3'h0)
    else $error("abort request created for an empty buffer");

  a_no_grant_init: assert property (
    init_mode |-> grant == 3'h0)
    else $error("abort granted in init mode");

  // Grants need a request and an idle engine; sent beats abort
  a_ack_needs_request: assert property (
    (state_reg.abak & ~$past(state_reg.abak) & ~$past(state_reg.abrq)) == 3'h0)
    else $error("acknowledge without pending abort request");

  a_ack_needs_idle: assert property (
    (state_reg.abak & ~$past(state_reg.abak) & $past(eng_active_i)) == 3'h0)
    else $error("abort granted during a transmission");

  a_grant_clears_req: assert property (
    grant != 3'h0 |=> (state_reg.abrq & $past(grant)) == 3'h0)
    else $error("abort request left pending after grant");

  a_grant_event: assert property (
    grant != 3'h0 |=> state_reg.evt_st[ctb_pkg::EVT_ABORTED])
    else $error("granted abort left no event");

  a_sent_not_aborted: assert property (
    (state_reg.abak & $past(eng_sent_i & ~state_reg.empty)) == 3'h0)
    else $error("sent buffer flagged as aborted");

  a_sent_sets_empty: assert property (
    (~state_reg.empty & $past(eng_sent_i & ~state_reg.empty)) == 3'h0)
    else $error("sent buffer not flagged empty");

  // Empty flags: only a normal-mode write of one schedules a buffer
  a_empty_write_clears: assert property (
    (wr_i && wr_ok && addr_i == ctb_pkg::OFS_EMPTY_FLAGS)
      |=> (state_reg.empty & $past(wdata_i[2:0] & state_reg.empty)) == 3'h0)
    else $error("write of one did not schedule buffer");

  a_empty_zero_kept: assert property (
    (wr_i && addr_i == ctb_pkg::OFS_EMPTY_FLAGS)
      |=> ($past(state_reg.empty & ~wdata_i[2:0]) & ~state_reg.empty) == 3'h0)
    else $error("write of zero scheduled a buffer");

  a_empty_no_write: assert property (
    !wr_ok |=> ($past(state_reg.empty) & ~state_reg.empty) == 3'h0)
    else $error("empty flag cleared outside normal mode");

  a_init_empty_held: assert property (
    init_mode |=> state_reg.empty == ctb_pkg::EMPTY_RST)
    else $error("empty flags not held in init mode");

  a_ack_clear_sched: assert property (
    (wr_i && wr_ok && addr_i == ctb_pkg::OFS_EMPTY_FLAGS)
      |=> (state_reg.abak & $past(wdata_i[2:0] & state_reg.empty)) == 3'h0)
    else $error("acknowledge kept after rescheduling");

  a_ack_no_write: assert property (
    (wr_i && addr_i == ctb_pkg::OFS_ABORT_ACKNOWLEDGE)
      |=> (state_reg.abak & ~$past(state_reg.abak | grant)) == 3'h0)
    else $error("acknowledge changed by a write");

  a_ack_only_grant: assert property (
    (state_reg.abak & ~$past(state_reg.abak) & ~$past(grant)) == 3'h0)
    else $error("acknowledge set without a granted abort");

  // Buffer select and transmit window
  a_select_one_hot: assert property (
    $onehot0(state_reg.bsel))
    else $error("more than one buffer selected");

  a_select_write_low: assert property (
    (wr_i && wr_ok && addr_i == ctb_pkg::OFS_BUFFER_SELECT)
      |=> ((state_reg.bsel - 3'h1) & $past(wdata_i[2:0])) == 3'h0
          && (state_reg.bsel & ~$past(wdata_i[2:0])) == 3'h0)
    else $error("buffer select did not keep the lowest written one");

  a_select_no_write: assert property (
    (wr_i && !wr_ok && addr_i == ctb_pkg::OFS_BUFFER_SELECT)
      |=> state_reg.bsel == $past(state_reg.bsel)
          || state_reg.bsel == ctb_pkg::BSEL_RST)
    else $error("buffer select written outside normal mode");

  a_open_allows: assert property (
    (wr_i || rd_i) && win_hit && (state_reg.bsel & state_reg.empty) != 3'h0
      |-> win_wr_o || win_rd_o)
    else $error("access to free selected buffer refused");

  a_blocked_read_zero: assert property (
    rd_i && win_hit && !window_open_o |=> rdata_o == ctb_pkg::RDATA_RST)
    else $error("blocked window read returned data");

  a_blocked_event: assert property (
    (wr_i || rd_i) && win_hit && !window_open_o |=> state_reg.evt_st[ctb_pkg::EVT_BLOCKED])
    else $error("blocked window access left no event");

  a_no_sel_closed: assert property (
    state_reg.bsel == 3'h0 |-> !window_open_o)
    else $error("window open with no buffer selected");

  // Read data must not linger, or a missed read looks fresh
  a_read_data_once: assert property (
    !rd_i |=> rdata_o == ctb_pkg::RDATA_RST)
    else $error("read data stood longer than one cycle");

endmodule // ctb_tx_buffer_control

// ---- dv/ctb_engine_model.sv ----
// Protocol engine stand-in: transmits scheduled buffers on bench command
`timescale 1ns/100ps

module ctb_engine_model (
  input wire logic mclk_i, // Module clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic [2:0] start_i, // Bench command: begin sending buffer
  input wire logic [2:0] scheduled_i, // Buffers the block has queued
  input wire logic fail_i, // Attempt ends lost or in error
  input wire logic [3:0] lat_i, // Frame length in cycles
  output logic [2:0] eng_sent_o, // Sent pulse
  output logic [2:0] eng_active_o, // Transmission under way
  output logic [7:0] win_rdata_o // Buffer contents
);
  logic [3:0] cnt [3];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eng_sent_o <= 3'h0;
      eng_active_o <= 3'h0;
      win_rdata_o <= 8'h5a;
      cnt <= '{default: 4'h0};
    end else begin
      // Never stable, so a stale read cannot pass for fresh data
      win_rdata_o <= win_rdata_o + 8'h35;
      for (int i = 0; i < 3; i++) begin
        eng_sent_o[i] <= 1'b0;
        if (start_i[i] && scheduled_i[i] && !eng_active_o[i]) begin
          eng_active_o[i] <= 1'b1;
          cnt[i] <= lat_i;
        end else if (eng_active_o[i]) begin
          cnt[i] <= cnt[i] - 4'h1;
          if (cnt[i] <= 4'h1) begin
            eng_active_o[i] <= 1'b0;
            eng_sent_o[i] <= !fail_i;
          end
        end
      end
    end
  end
endmodule // ctb_engine_model

// ---- dv/tb_ctb_tx_buffer_control.sv ----
// Self-checking bench for the transmit buffer control block
`timescale 1ns/100ps

module tb_ctb_tx_buffer_control;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata, wrd, wwd, exp_rd, r8;
  logic wr_i = 1'b0, rd_i = 1'b0, ireq = 1'b0, iack = 1'b0, fail = 1'b0;
  logic [2:0] start = 3'h0, sent, active, sched, abrq, wsel;
  logic [2:0] m_empty, m_en, m_abrq, m_abak, m_bsel, m_evt, m_een;
  logic [3:0] lat = 4'h1, waddr;
  logic wopen, wwr, wrdo, tirq, irq;
  logic [7:0] amap [8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h10, 8'h12, 8'h24};
  int failures = 0, checks = 0, seed = 32'he93a, r;
  wire inw = (wr_i || rd_i) && addr_i[7:4] == 4'h2;
  wire opn = |(m_bsel & m_empty);

  always #12.5 mclk_i = ~mclk_i;

  ctb_tx_buffer_control dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .init_request_i(ireq),
    .init_acknowledge_i(iack), .eng_sent_i(sent), .eng_active_i(active), .scheduled_o(sched),
    .abort_req_o(abrq), .window_sel_o(wsel), .window_open_o(wopen), .win_wr_o(wwr),
    .win_rd_o(wrdo), .win_addr_o(waddr), .win_wdata_o(wwd), .win_rdata_i(wrd),
    .tx_empty_irq_o(tirq), .irq_o(irq));

  ctb_engine_model eng_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(start),
    .scheduled_i(sched), .fail_i(fail), .lat_i(lat), .eng_sent_o(sent),
    .eng_active_o(active), .win_rdata_o(wrd));

  // Reference model, updated on the same edges as the design
  always @(posedge mclk_i or negedge rst_n_i) begin : model
    logic [2:0] sc, gr, st, wv;
    logic act, wok;
    if (!rst_n_i) begin
      m_empty <= 3'h7;
      {m_en, m_abrq, m_abak, m_bsel, m_evt, m_een} <= 18'h0;
      exp_rd <= 8'h00;
    end else begin
      sc = ~m_empty;
      act = ireq && iack;
      wok = wr_i && !ireq && !iack;
      wv = wok ? wdata_i[2:0] : 3'h0;
      gr = act ? 3'h0 : m_abrq & sc & ~active & ~sent;
      st = (sent & sc) | gr;
      exp_rd <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          8'h06: exp_rd <= {5'h0, m_empty};
          8'h07: exp_rd <= {5'h0, m_en};
          8'h08: exp_rd <= {5'h0, m_abrq};
          8'h09: exp_rd <= {5'h0, m_abak};
          8'h0a: exp_rd <= {5'h0, m_bsel};
          8'h10: exp_rd <= {5'h0, m_evt};
          8'h11: exp_rd <= {5'h0, m_een};
          default: exp_rd <= inw && opn ? wrd : 8'h00;
        endcase
      end
      if (act) begin
        m_empty <= 3'h7;
        {m_en, m_abrq, m_abak, m_bsel} <= 12'h0;
      end else begin
        m_empty <= (m_empty & ~(addr_i == 8'h06 ? wv : 3'h0)) | st;
        m_abak <= (m_abak & ~(addr_i == 8'h06 ? wv : 3'h0)) | gr;
        m_abrq <= (m_abrq | (addr_i == 8'h08 ? wv & sc : 3'h0)) & ~st;
        if (wok && addr_i == 8'h07) m_en <= wdata_i[2:0];
        if (wok && addr_i == 8'h0a) m_bsel <= wdata_i[2:0] & (~wdata_i[2:0] + 3'h1);
      end
      m_evt <= (m_evt & ~(wr_i && addr_i == 8'h12 ? wdata_i[2:0] : 3'h0))
        | {inw && !opn, |gr, |(sent & sc)};
      if (wr_i && addr_i == 8'h11) m_een <= wdata_i[2:0];
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(negedge mclk_i) begin
    if (rst_n_i) begin
      chk({sched, abrq, wsel}, {~m_empty, m_abrq, m_bsel});
      chk({wopen, tirq, irq}, {opn, |(m_empty & m_en), |(m_evt & m_een)});
      chk({wwr, wrdo}, {wr_i && inw && opn, rd_i && inw && opn});
      chk({waddr, wwd}, {addr_i[3:0], wdata_i});
      chk(rdata, exp_rd);
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1;
    if (!w) chk(rdata, exp_rd);
  endtask

  task automatic pulse(input logic [2:0] v, input logic [3:0] l, input logic f);
    @(posedge mclk_i);
    start <= v;
    lat <= l;
    fail <= f;
    @(posedge mclk_i);
    start <= 3'h0;
  endtask

  task automatic wrap_up();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #500000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 8'h30; a++) bus(1'b0, a[7:0], 8'h00);
    $display("test reset_map done");
    for (int v = 0; v < 8; v++) begin
      bus(1'b1, 8'h0a, 8'hf8 | v[7:0]);
      bus(1'b0, 8'h0a, 8'h00);
      bus(1'b1, 8'h2b, 8'h3c);
      bus(1'b0, 8'h21, 8'h00);
    end
    $display("test select done");
    bus(1'b1, 8'h07, 8'h05);
    bus(1'b1, 8'h11, 8'h07);
    bus(1'b1, 8'h06, 8'h07);
    bus(1'b1, 8'h0a, 8'h01);
    bus(1'b1, 8'h2f, 8'h11);
    pulse(3'h2, 4'hf, 1'b0);
    bus(1'b1, 8'h08, 8'hff);
    bus(1'b1, 8'h08, 8'h00);
    bus(1'b0, 8'h08, 8'h00);
    repeat (20) @(posedge mclk_i);
    for (int a = 6; a < 'h11; a++) bus(1'b0, a[7:0], 8'h00);
    bus(1'b1, 8'h09, 8'h00);
    bus(1'b1, 8'h06, 8'h02);
    bus(1'b0, 8'h09, 8'h00);
    pulse(3'h2, 4'h6, 1'b1);
    bus(1'b1, 8'h08, 8'h02);
    repeat (10) @(posedge mclk_i);
    bus(1'b0, 8'h09, 8'h00);
    bus(1'b1, 8'h12, 8'h07);
    bus(1'b0, 8'h10, 8'h00);
    $display("test abort done");
    bus(1'b1, 8'h06, 8'h01);
    bus(1'b0, 8'h06, 8'h00);
    bus(1'b1, 8'h0a, rdata);
    bus(1'b0, 8'h0a, 8'h00);
    @(posedge mclk_i) ireq <= 1'b1;
    bus(1'b1, 8'h07, 8'h02);
    bus(1'b1, 8'h08, 8'h01);
    @(posedge mclk_i) iack <= 1'b1;
    for (int a = 6; a < 'h0b; a++) bus(1'b1, a[7:0], 8'h07);
    for (int a = 6; a < 'h0b; a++) bus(1'b0, a[7:0], 8'h00);
    @(posedge mclk_i) ireq <= 1'b0;
    bus(1'b1, 8'h07, 8'h07);
    @(posedge mclk_i) iack <= 1'b0;
    $display("test init done");
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      r8 = r[31:24];
      if (r[15:13] == 3'h0) pulse(r[18:16], r[11:8], r[12]);
      bus(r[19], amap[r[22:20]], r8);
    end
    $display("test random done");
    wrap_up();
  end
endmodule // tb_ctb_tx_buffer_control
